// >>> common/scgts_pkg.sv
// Package: register map, field positions and carrier types of the test-clock gate block
`default_nettype none
package scgts_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LEN_W = 32;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned NUM_MS = 2;
  localparam int unsigned BITCNT_W = 3;

  // Byte addresses of the register words
  localparam logic [ADDR_W-1:0] OFS_CTRL0 = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL1 = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_MS_A_DATA = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_MS_B_DATA = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_LENGTH = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h18;

  // Control register 0
  localparam int unsigned CTRL0_LOOPBACK_BIT = 0;
  localparam int unsigned CTRL0_AUTO_HIGH_BIT = 1;
  // Control register 1
  localparam int unsigned CTRL1_FREEZE_EN_BIT = 2;
  // Enable register: bits 0 and 1 are the two mode-select serializers
  localparam int unsigned EN_MS_BASE_BIT = 0;
  localparam int unsigned EN_LENGTH_BIT = 2;
  // Status register
  localparam int unsigned ST_MS_FULL_BASE_BIT = 0;
  localparam int unsigned ST_MS_EMPTY_BASE_BIT = 2;
  localparam int unsigned ST_LOADED_BIT = 4;
  localparam int unsigned ST_TERMINAL_BIT = 5;
  localparam int unsigned ST_TCK_RUN_BIT = 6;
  localparam int unsigned ST_BITCNT_LSB = 8;

  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [LEN_W-1:0] LENGTH_RST = 32'h0000_0000;
  localparam logic [BITCNT_W-1:0] BITCNT_LAST = 3'h7;
  localparam logic [LEN_W-1:0] LENGTH_LAST = 32'h0000_0001;

  // Status of the test-data shifters that sit beside this block
  typedef struct packed {
    logic tdo_en;
    logic tdo_empty;
    logic pseudo_random_pattern_mode;
    logic pattern_seed_loaded;
    logic tdi_en;
    logic tdi_full;
    logic signature_compaction_mode;
    logic signature_seed_loaded;
  } scgts_shifter_status_t;

  // Timing handed to the test-data shifters, all aligned to the test clock
  typedef struct packed {
    logic run;
    logic swap;
    logic last;
  } scgts_tck_timing_t;
endpackage
`default_nettype wire

// >>> rtl/scgts_ms_serializer.sv
// Double-buffered mode-select serializer: two byte registers, one shifting, one filling
`default_nettype none
module scgts_ms_serializer #(
  parameter int unsigned W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_valid,
  input wire logic [W-1:0] wr_data,
  input wire logic shift,
  input wire logic swap,
  output logic full,
  output logic empty,
  output logic head
);
  logic [W-1:0] data_q [2];
  logic [1:0] vld_q;
  logic act_q;
  wire logic wr_sel = vld_q[act_q] ? ~act_q : act_q;
  wire logic wr_ok = wr_valid & ~full;

  assign full = vld_q[0] & vld_q[1];
  assign empty = ~vld_q[act_q];
  assign head = data_q[act_q][0];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      data_q[0] <= '0;
      data_q[1] <= '0;
      vld_q <= 2'h0;
      act_q <= 1'b0;
    end
    else
    begin
      if (shift)
        data_q[act_q] <= data_q[act_q] >> 1;
      if (swap)
      begin
        vld_q[act_q] <= 1'b0;
        act_q <= ~act_q;
      end
      if (wr_ok)
      begin
        data_q[wr_sel] <= wr_data;
        vld_q[wr_sel] <= 1'b1;
      end
    end
  end

  property p_full_drop;
    @(posedge clk) disable iff (!rst_n) (wr_valid && full && !swap) |=> full;
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("write to full serializer changed its fill");

  property p_swap_discard;
    @(posedge clk) disable iff (!rst_n) swap |=> (act_q != $past(act_q)) && !vld_q[$past(act_q)];
  endproperty
  a_swap_discard: assert property (p_swap_discard) else $error("swap kept the outgoing register");
endmodule
`default_nettype wire

// >>> rtl/scgts_tck_gate.sv
// Test-clock gate, scan length and bit-in-byte counters, mode-select outputs, register slave
// Functional notes
// - Clock enable changes only while system clock is low; test clock stops low.
// - Stop clock when data-out enabled and empty, or seeding unfinished.
// - Stop clock when data-in enabled and full, or compaction seed unfinished.
// - Stop clock when an enabled mode-select serializer is empty.
// - Stop clock when length counter enabled and unloaded or at terminal count.
// - Bit-in-byte counter swaps serializer registers every 8 cycles and at terminal.
// - Bit-in-byte counter clears at terminal count and at reset.
// - Freeze enable plus high freeze pin drives test clock high asynchronously.
// - Freeze gates only the clock output; shifting and counting carry on.
// - Host loads length counter; serializer status pauses clock for host access.
// - With length counter disabled, serializer status alone starts and stops clock.
// - Each mode-select serializer is two byte registers, one shifting, one filling.
// - Mode-select outputs change on falling clock edge, least bit first.
// - Mode-select outputs high in reset, released when output enable pin high.
// - Writes accepted unless full, enabled or not; writes when full dropped.
// - Serializer shifts only when enabled, holding data, and clock permitted.
// - Outside automatic high, mode-select outputs hold when not shifting or during loop-back.
// - Terminal-count swap discards unshifted bits of outgoing register.
// - Automatic high forces both mode-select outputs to 1 when count equals 1.
`default_nettype none
module scgts_tck_gate #(
  parameter int unsigned LEN_W = scgts_pkg::LEN_W,
  parameter int unsigned MS_W = scgts_pkg::BYTE_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [scgts_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [scgts_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [scgts_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire scgts_pkg::scgts_shifter_status_t shifter_status,
  output scgts_pkg::scgts_tck_timing_t tck_timing,
  input wire logic freeze_pin,
  input wire logic out_enable_n,
  output logic test_clock,
  output logic [scgts_pkg::NUM_MS-1:0] mode_select_out,
  output logic [scgts_pkg::NUM_MS-1:0] mode_select_oe
);
  localparam int unsigned NMS = scgts_pkg::NUM_MS;

  // Bus slave state
  logic wait_q;
  logic [scgts_pkg::DATA_W-1:0] rdata_q;
  logic [scgts_pkg::DATA_W-1:0] ctrl0_q;
  logic [scgts_pkg::DATA_W-1:0] ctrl1_q;
  logic [scgts_pkg::DATA_W-1:0] enable_q;

  // Counters and gate state
  logic [LEN_W-1:0] len_q;
  logic loaded_q;
  logic [scgts_pkg::BITCNT_W-1:0] bit_q;
  logic tck_en_q;
  logic swap_q;
  logic last_q;
  logic [NMS-1:0] ms_q;
  logic [NMS-1:0] oe_s1_q;
  logic [NMS-1:0] oe_s2_q;
  logic [NMS-1:0] oe_q;

  // Address decode
  wire logic req = avs_read | avs_write;
  wire logic accept = req & ~wait_q;
  wire logic wr_acc = accept & avs_write;
  wire logic hit_ctrl0 = avs_address == scgts_pkg::OFS_CTRL0;
  wire logic hit_ctrl1 = avs_address == scgts_pkg::OFS_CTRL1;
  wire logic hit_enable = avs_address == scgts_pkg::OFS_ENABLE;
  wire logic hit_ms_a = avs_address == scgts_pkg::OFS_MS_A_DATA;
  wire logic hit_ms_b = avs_address == scgts_pkg::OFS_MS_B_DATA;
  wire logic hit_length = avs_address == scgts_pkg::OFS_LENGTH;
  wire logic hit_status = avs_address == scgts_pkg::OFS_STATUS;
  wire logic [NMS-1:0] hit_ms = {hit_ms_b, hit_ms_a};

  // Control fields
  wire logic loopback = ctrl0_q[scgts_pkg::CTRL0_LOOPBACK_BIT];
  wire logic auto_high = ctrl0_q[scgts_pkg::CTRL0_AUTO_HIGH_BIT];
  wire logic freeze_en = ctrl1_q[scgts_pkg::CTRL1_FREEZE_EN_BIT];
  wire logic len_en = enable_q[scgts_pkg::EN_LENGTH_BIT];
  wire logic [NMS-1:0] ms_en = enable_q[scgts_pkg::EN_MS_BASE_BIT +: NMS];

  // Byte-lane merge for the length load
  logic [LEN_W-1:0] lane_mask;
  genvar gl;
  generate
    for (gl = 0; gl < LEN_W / scgts_pkg::BYTE_W; gl++)
    begin : g_lane
      assign lane_mask[gl*scgts_pkg::BYTE_W +: scgts_pkg::BYTE_W] = {scgts_pkg::BYTE_W{avs_byteenable[gl]}};
    end
  endgenerate
  wire logic [LEN_W-1:0] len_load = (len_q & ~lane_mask) | (avs_writedata[LEN_W-1:0] & lane_mask);

  // Serializer status
  logic [NMS-1:0] ms_full;
  logic [NMS-1:0] ms_empty;
  logic [NMS-1:0] ms_head;

  // Test-clock events at the rising system edge, all decided at the falling edge before
  wire logic step = tck_en_q;
  wire logic swap_evt = swap_q;
  wire logic tc_evt = last_q;

  wire logic terminal = len_en & loaded_q & (len_q == '0);
  wire logic len_stop = len_en & (~loaded_q | (len_q == '0));
  wire logic tdo_stop = shifter_status.tdo_en &
    (shifter_status.tdo_empty | (shifter_status.pseudo_random_pattern_mode & ~shifter_status.pattern_seed_loaded));
  wire logic tdi_stop = shifter_status.tdi_en &
    (shifter_status.tdi_full | (shifter_status.signature_compaction_mode & ~shifter_status.signature_seed_loaded));
  wire logic ms_stop = |(ms_en & ms_empty);
  // Freeze stays out of the stop terms: it must not stall shifting or counting
  // Status alone when counter off
  wire logic go_d = ~(len_stop | tdo_stop | tdi_stop | ms_stop);
  wire logic at_last = len_en & loaded_q & (len_q == scgts_pkg::LENGTH_LAST);
  wire logic byte_end = bit_q == scgts_pkg::BITCNT_LAST;
  wire logic force_high = auto_high & at_last;
  // Counter parks at zero; only a host load restarts it
  wire logic len_dec = step & len_en & loaded_q & (len_q != '0);

  // Bit 7 is spare and reads as zero
  wire logic [scgts_pkg::DATA_W-1:0] status_word = {
    {(scgts_pkg::DATA_W - scgts_pkg::ST_BITCNT_LSB - scgts_pkg::BITCNT_W){1'b0}},
    bit_q, 1'b0, tck_en_q, terminal, loaded_q, ms_empty, ms_full};
  wire logic [scgts_pkg::DATA_W-1:0] rd_mux =
    hit_ctrl0 ? ctrl0_q :
    hit_ctrl1 ? ctrl1_q :
    hit_enable ? enable_q :
    hit_length ? len_q :
    hit_status ? status_word : '0;

  // Bus slave: waitrequest drops for one cycle on the edge after the request is seen
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wait_q <= 1'b1;
      rdata_q <= '0;
    end
    else
    begin
      wait_q <= ~(req & wait_q);
      if (avs_read & wait_q)
        rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl0_q <= scgts_pkg::CTRL_RST;
      ctrl1_q <= scgts_pkg::CTRL_RST;
      enable_q <= scgts_pkg::CTRL_RST;
    end
    else
    begin
      if (wr_acc & hit_ctrl0)
        ctrl0_q <= avs_writedata;
      if (wr_acc & hit_ctrl1)
        ctrl1_q <= avs_writedata;
      if (wr_acc & hit_enable)
        enable_q <= avs_writedata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      len_q <= scgts_pkg::LENGTH_RST;
      loaded_q <= 1'b0;
    end
    else if (wr_acc & hit_length)
    begin
      len_q <= len_load;
      loaded_q <= 1'b1;
    end
    else if (len_dec)
      len_q <= len_q - LEN_W'(1);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      bit_q <= '0;
    else if (tc_evt)
      bit_q <= '0;
    else if (step)
      bit_q <= bit_q + scgts_pkg::BITCNT_W'(1);
  end

  always_ff @(negedge clk)
  begin
    if (!rst_n)
    begin
      tck_en_q <= 1'b0;
      swap_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      tck_en_q <= go_d;
      swap_q <= go_d & (byte_end | at_last);
      last_q <= go_d & at_last;
    end
  end

  assign test_clock = (clk & tck_en_q) | (freeze_en & freeze_pin);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tck_timing <= '0;
    else
    begin
      tck_timing.run <= go_d;
      tck_timing.swap <= go_d & (byte_end | at_last);
      tck_timing.last <= go_d & at_last;
    end
  end

  genvar gc;
  generate
    for (gc = 0; gc < NMS; gc++)
    begin : g_ms
      wire logic may_shift = ms_en[gc] & ~ms_empty[gc] & ~loopback;

      scgts_ms_serializer #(
        .W(MS_W)
      ) u_ser (
        .clk(clk),
        .rst_n(rst_n),
        .wr_valid(wr_acc & hit_ms[gc]),
        .wr_data(avs_writedata[MS_W-1:0]),
        .shift(step & may_shift),
        .swap(swap_evt & ms_en[gc]),
        .full(ms_full[gc]),
        .empty(ms_empty[gc]),
        .head(ms_head[gc])
      );

      always_ff @(negedge clk)
      begin
        if (!rst_n)
          ms_q[gc] <= 1'b1;
        else if (force_high)
          ms_q[gc] <= 1'b1;
        else if (go_d & may_shift)
          ms_q[gc] <= ms_head[gc];
      end

      // Output enable pin is asynchronous, so it is brought in through two stages
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          oe_s1_q[gc] <= 1'b0;
          oe_s2_q[gc] <= 1'b0;
          oe_q[gc] <= 1'b1;
        end
        else
        begin
          oe_s1_q[gc] <= out_enable_n;
          oe_s2_q[gc] <= oe_s1_q[gc];
          oe_q[gc] <= ~oe_s2_q[gc];
        end
      end

      // High in reset, release on pin
      // Pad enable comes from a flop, so it cannot glitch as reset lets go
      assign mode_select_oe[gc] = oe_q[gc];

      property p_ms_empty_stop;
        @(posedge clk) disable iff (!rst_n) (ms_en[gc] && ms_empty[gc]) |-> !tck_en_q;
      endproperty
      a_ms_empty_stop: assert property (p_ms_empty_stop) else $error("clock ran on empty serializer");
    end
  endgenerate

  assign mode_select_out = ms_q;
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  property p_tdo_stop;
    @(posedge clk) disable iff (!rst_n) tdo_stop |-> !step;
  endproperty
  a_tdo_stop: assert property (p_tdo_stop) else $error("clock ran while data-out starved");

  property p_tdi_stop;
    @(posedge clk) disable iff (!rst_n) tdi_stop |-> !step;
  endproperty
  a_tdi_stop: assert property (p_tdi_stop) else $error("clock ran while data-in blocked");

  property p_len_stop;
    @(posedge clk) disable iff (!rst_n) (len_en && (!loaded_q || len_q == '0)) |-> !step;
  endproperty
  a_len_stop: assert property (p_len_stop) else $error("clock ran with counter unloaded or done");

  sequence s_byte_done;
    step && byte_end && !tc_evt;
  endsequence
  property p_byte_wrap;
    @(posedge clk) disable iff (!rst_n) s_byte_done |-> swap_evt ##1 (bit_q == '0);
  endproperty
  a_byte_wrap: assert property (p_byte_wrap) else $error("no swap after eight cycles");

  property p_tc_clear;
    @(posedge clk) disable iff (!rst_n) tc_evt |-> swap_evt ##1 (bit_q == '0 && len_q == '0);
  endproperty
  a_tc_clear: assert property (p_tc_clear) else $error("terminal count did not realign");

  property p_auto_high;
    @(posedge clk) disable iff (!rst_n) force_high |=> (ms_q == '1);
  endproperty
  a_auto_high: assert property (p_auto_high) else $error("final bit not forced high");

  property p_loop_hold;
    @(posedge clk) disable iff (!rst_n) (loopback && !force_high) |=> $stable(ms_q);
  endproperty
  a_loop_hold: assert property (p_loop_hold) else $error("mode-select moved during loop-back");
endmodule
`default_nettype wire

// >>> dv/scgts_scan_chain_model.sv
// Behavioural scan chains on both mode-select lines: counts test clocks, captures bits
`default_nettype none
module scgts_scan_chain_model (
  input wire logic test_clock,
  input wire logic [1:0] tms,
  output logic [31:0] edges = 32'h0000_0000,
  output logic [15:0] cap_a,
  output logic [15:0] cap_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // sampled on rise, first bit ends lowest
  always @(posedge test_clock)
  begin
    edges <= edges + 32'h0000_0001;
    cap_a <= {tms[0], cap_a[15:1]};
    cap_b <= {tms[1], cap_b[15:1]};
  end
endmodule
`default_nettype wire

// >>> dv/scgts_tck_gate_bench.sv
// Bench for the test-clock gate: register tasks, link scenarios and checks
`default_nettype none
module scgts_tck_gate_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] STOP = 8'hc0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [scgts_pkg::ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  scgts_pkg::scgts_shifter_status_t shifter_status = STOP;
  scgts_pkg::scgts_shifter_status_t stops [4] = '{8'hc0, 8'ha0, 8'h0c, 8'h0a};
  logic freeze_pin = 1'b0;
  logic out_enable_n = 1'b0;
  logic test_clock;
  logic [1:0] ms_out;
  logic [1:0] ms_oe;
  logic [1:0] ms_pin;
  scgts_pkg::scgts_tck_timing_t timing;
  logic [31:0] edges;
  logic [15:0] cap_a;
  logic [15:0] cap_b;
  logic [31:0] q;
  logic [31:0] d;
  logic last_a;
  int fails = 0;
  int n_checks = 0;

  always #5 clk = ~clk;

  // Pull-up on a released mode-select line
  assign ms_pin = (ms_oe & ms_out) | ~ms_oe;

  scgts_tck_gate dut (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .shifter_status(shifter_status), .tck_timing(timing),
    .freeze_pin(freeze_pin), .out_enable_n(out_enable_n), .test_clock(test_clock),
    .mode_select_out(ms_out), .mode_select_oe(ms_oe)
  );

  scgts_scan_chain_model chain (.test_clock(test_clock), .tms(ms_pin), .edges(edges), .cap_a(cap_a), .cap_b(cap_b));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic is_wr, input logic [scgts_pkg::ADDR_W-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    avs_address <= a;
    avs_write <= is_wr;
    avs_read <= ~is_wr;
    avs_writedata <= wd;
    @(posedge clk);
    // Wait as long as the slave asks; only the watchdog ends a hang
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [scgts_pkg::ADDR_W-1:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, a, wd, dummy);
  endtask

  // Test-clock edges seen by the chains over n cycles, sampled off the edge
  task automatic measure(input int n, output logic [31:0] cnt);
    logic [31:0] s;
    @(negedge clk);
    s = edges;
    repeat (n) @(negedge clk);
    cnt = edges - s;
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #50000;
    fails++;
    close_out();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    check(32'(ms_out), 32'h0000_0003);
    check(32'(ms_oe), 32'h0000_0003);
    rst_n <= 1'b1;
    bus(1'b0, scgts_pkg::OFS_STATUS, 32'h0000_0000, q);
    check(q & 32'h0000_077f, 32'h0000_000c);
    bus(1'b0, 5'h1c, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
    // Chain B stays idle, as if parked, under auto high
    wr(scgts_pkg::OFS_MS_A_DATA, 32'h0000_0003);
    wr(scgts_pkg::OFS_CTRL0, 32'h0000_0002);
    wr(scgts_pkg::OFS_ENABLE, 32'h0000_0005);
    shifter_status <= '0;
    measure(10, d);
    check(d, 32'h0000_0000);
    wr(scgts_pkg::OFS_LENGTH, 32'h0000_0003);
    measure(30, d);
    check(d, 32'h0000_0003);
    check(32'(cap_a[15:13]), 32'h0000_0007);
    bus(1'b0, scgts_pkg::OFS_STATUS, 32'h0000_0000, q);
    check(q & 32'h0000_0724, 32'h0000_0024);
    wr(scgts_pkg::OFS_CTRL0, 32'h0000_0000);
    wr(scgts_pkg::OFS_MS_A_DATA, 32'h0000_0005);
    wr(scgts_pkg::OFS_LENGTH, 32'h0000_0002);
    measure(30, d);
    check(d, 32'h0000_0002);
    check(32'(cap_a[15:14]), 32'h0000_0001);
    // One byte after a discarding swap must leave room for another
    wr(scgts_pkg::OFS_MS_A_DATA, 32'h0000_0001);
    bus(1'b0, scgts_pkg::OFS_STATUS, 32'h0000_0000, q);
    check(q & 32'h0000_0001, 32'h0000_0000);
    wr(scgts_pkg::OFS_ENABLE, 32'h0000_0002);
    measure(20, d);
    check(d, 32'h0000_0000);
    @(posedge clk);
    shifter_status <= STOP;
    wr(scgts_pkg::OFS_MS_B_DATA, 32'h0000_00a5);
    wr(scgts_pkg::OFS_MS_B_DATA, 32'h0000_003c);
    wr(scgts_pkg::OFS_MS_B_DATA, 32'h0000_00ff);
    bus(1'b0, scgts_pkg::OFS_STATUS, 32'h0000_0000, q);
    check(q & 32'h0000_0003, 32'h0000_0002);
    shifter_status <= '0;
    measure(40, d);
    check(d, 32'h0000_0010);
    check(32'(cap_b), 32'h0000_3ca5);
    bus(1'b0, scgts_pkg::OFS_STATUS, 32'h0000_0000, q);
    check(q & 32'h0000_0008, 32'h0000_0008);
    wr(scgts_pkg::OFS_ENABLE, 32'h0000_0000);
    foreach (stops[i])
    begin
      @(posedge clk);
      shifter_status <= stops[i];
      repeat (3) @(posedge clk);
      measure(12, d);
      if (i < 2)
        check(d, 32'h0000_0000);
      else
        check(d, 32'h0000_0000);
    end
    @(posedge clk);
    shifter_status <= '0;
    repeat (3) @(posedge clk);
    measure(12, d);
    check(d, 32'h0000_000c);
    check(32'(timing.run), 32'h0000_0001);
    // Freeze is used only while the test clock is held stopped
    @(posedge clk);
    shifter_status <= STOP;
    wr(scgts_pkg::OFS_CTRL1, 32'h0000_0004);
    check(32'(timing), 32'h0000_0000);
    @(posedge clk);
    freeze_pin <= 1'b1;
    @(negedge clk);
    check(32'(test_clock), 32'h0000_0001);
    @(posedge clk);
    freeze_pin <= 1'b0;
    @(negedge clk);
    check(32'(test_clock), 32'h0000_0000);
    @(posedge clk);
    freeze_pin <= 1'b1;
    wr(scgts_pkg::OFS_CTRL1, 32'h0000_0000);
    @(negedge clk);
    check(32'(test_clock), 32'h0000_0000);
    @(posedge clk);
    freeze_pin <= 1'b0;
    out_enable_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(32'(ms_oe), 32'h0000_0000);
    out_enable_n <= 1'b0;
    repeat (4) @(posedge clk);
    check(32'(ms_oe), 32'h0000_0003);
    // Loop-back: data of the opposite level must not reach the line
    last_a = ms_out[0];
    wr(scgts_pkg::OFS_CTRL0, 32'h0000_0001);
    wr(scgts_pkg::OFS_ENABLE, 32'h0000_0001);
    wr(scgts_pkg::OFS_MS_A_DATA, last_a ? 32'h0000_0000 : 32'h0000_00ff);
    shifter_status <= '0;
    measure(20, d);
    check(32'(ms_out[0]), 32'(last_a));
    close_out();
  end
endmodule
`default_nettype wire
